// >>> logic_block_pkg.sv
// shared constants and types of the product-term logic block
package logic_block_pkg;

   // ****************************************
   // sizes
   // ****************************************
   localparam int NUM_INPUTS = 26;
   localparam int NUM_LOGIC_TERMS = 48;
   localparam int NUM_TERMS = 52;
   localparam int NUM_MC = 12;
   localparam int NUM_IO = 6;
   localparam int NUM_CLK_PINS = 4;
   localparam int CLUSTER_TERMS = 4;
   localparam int MAX_CELL_TERMS = 16;
   localparam int TERM_OE0 = 48;
   localparam int TERM_OE1 = 49;
   localparam int TERM_RESET = 50;
   localparam int TERM_PRESET = 51;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam int ADDR_W = 10;
   localparam logic [9:0] TERM_BASE = 10'h000;
   localparam logic [9:0] TERM_STRIDE = 10'h008;
   localparam logic [9:0] TERM_COMP_OFS = 10'h004;
   localparam logic [9:0] MC_BASE = 10'h200;
   localparam logic [9:0] STEER_BASE = 10'h240;
   localparam logic [9:0] IO_BASE = 10'h280;
   localparam logic [9:0] STATUS_ADDR = 10'h2c0;
   localparam logic [9:0] WORD_STRIDE = 10'h004;
   localparam int STATUS_MC_LSB = 0;
   localparam int STATUS_PIN_LSB = 12;

   // ****************************************
   // types and reset values
   // ****************************************
   typedef enum logic [1:0] {
      MC_COMB = 2'h0,
      MC_REG = 2'h1,
      MC_LATCH = 2'h3,
      MC_INPUT = 2'h2
   } mc_mode_t;
   typedef enum logic [1:0] {
      OE_ALWAYS = 2'h0,
      OE_NEVER = 2'h1,
      OE_TERM0 = 2'h2,
      OE_TERM1 = 2'h3
   } oe_mode_t;
   // bits [1:0] mode, [2] toggle, [3] invert, [5:4] clock select
   typedef struct packed {
      logic [1:0] clk_sel;
      logic invert;
      logic toggle;
      mc_mode_t mode;
   } mc_cfg_t;
   typedef struct packed {
      logic reset;
      logic preset;
   } init_terms_t;
   typedef struct packed {
      logic [25:0] true_mask;
      logic [25:0] comp_mask;
   } term_fuse_t;
   localparam logic [25:0] MASK_RESET = 26'h3ffffff;
   localparam mc_cfg_t MC_CFG_RESET = 6'h00;
   localparam logic [1:0] STEER_RESET = 2'h2;
   localparam oe_mode_t IO_MODE_RESET = OE_NEVER;
   localparam logic [3:0] CLK_PIN_RESET = 4'hf;

endpackage : logic_block_pkg

// >>> io_cell.sv
// three-state output driver of one pin
`timescale 1ns/100ps
`default_nettype none
module io_cell
   import logic_block_pkg::*;
(
   input wire oe_mode_t mode,
   input wire logic [1:0] oe_terms,
   input wire logic data,
   output logic pin_out,
   output logic pin_oe_n
);
   always_comb begin
      pin_out = data;
      unique case (mode)
         OE_ALWAYS: pin_oe_n = 1'b0;
         OE_NEVER: pin_oe_n = 1'b1;
         OE_TERM0: pin_oe_n = ~oe_terms[0];
         OE_TERM1: pin_oe_n = ~oe_terms[1];
      endcase
   end
endmodule : io_cell
`default_nettype wire

// >>> macrocell.sv
// one macrocell: combinatorial, register, latch or input sampler
`timescale 1ns/100ps
`default_nettype none
module macrocell
   import logic_block_pkg::*;
#(
   parameter bit BURIED = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire mc_cfg_t cfg,
   input wire logic sum,
   input wire logic pin_in,
   input wire logic [3:0] clk_pins,
   input wire logic [3:0] clk_rise,
   input wire init_terms_t init,
   output logic q_out
);
   logic stored, next_stored, data, gate, rise, in_mode;
   logic use_latch, use_reg;

   always_comb begin
      in_mode = BURIED && (cfg.mode == MC_INPUT);
      data = in_mode ? pin_in : (sum ^ cfg.invert);
      gate = clk_pins[cfg.clk_sel];
      rise = clk_rise[cfg.clk_sel];
      use_latch = (cfg.mode == MC_LATCH) || (in_mode && cfg.toggle);
      use_reg = (cfg.mode == MC_REG) || (in_mode && !cfg.toggle);
      // reset beats preset
      if (init.reset) begin
         next_stored = 1'b0;
      end else if (init.preset) begin
         next_stored = 1'b1;
      end else if (use_latch) begin
         next_stored = gate ? stored : data;
      end else if (use_reg && rise) begin
         next_stored = (cfg.toggle && !in_mode) ? stored ^ data : data;
      end else begin
         next_stored = stored;
      end
      // the forced value shows at once, not only after the next edge
      if (!use_latch && !use_reg) begin
         q_out = data;
      end else if (init.reset) begin
         q_out = 1'b0;
      end else if (init.preset) begin
         q_out = 1'b1;
      end else if (use_latch) begin
         q_out = gate ? stored : data;
      end else begin
         q_out = stored;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stored <= 1'b0;
      end else begin
         stored <= next_stored;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence gate_held;
      use_latch && gate && !init.reset && !init.preset;
   endsequence
   chk_reset_wins: assert property ((use_latch || use_reg) && init.reset |-> !q_out ##1 !stored)
      else $error("reset term did not clear the storage element");
   chk_preset_forces: assert property (
      (use_latch || use_reg) && init.preset && !init.reset |-> q_out ##1 stored)
      else $error("preset term did not set the storage element");
   chk_d_capture: assert property (cfg.mode == MC_REG && !cfg.toggle && rise && init == 2'h0
      |=> stored == $past(data))
      else $error("d register missed its clock edge");
   chk_toggle_step: assert property (cfg.mode == MC_REG && cfg.toggle && rise && init == 2'h0
      |=> stored == ($past(stored) ^ $past(data)))
      else $error("t register did not toggle on a true input");
   chk_latch_hold: assert property (gate_held ##1 gate_held |-> $stable(q_out))
      else $error("latch changed while its gate was high");
   chk_input_sample: assert property (
      in_mode && !cfg.toggle && rise && init == 2'h0 |=> stored == $past(pin_in))
      else $error("input register did not sample its pin");
endmodule : macrocell
`default_nettype wire

// >>> logic_block.sv
// product-term logic block with its array, allocator, macrocells and pins
// What this block does
// - 48-term array, allocator, 6+6 macrocells, 6 pins
// - exactly 26 switch-matrix inputs feed the terms
// - four special terms: two enables, reset, preset
// - all storage initialised together, never singly
// - returns twelve macrocell and six pin feedbacks
// - allocator shares 48 terms, sixteen per macrocell
// - macrocell n reaches clusters n-1 to n+2
// - output cell registered, latched or combinatorial, polarity
// - feedback driven with or without storage element
// - register acts as d or toggle flip-flop
// - each element picks one of four clock pins
// - registers capture on rising edge of clock
// - latch passes while gate low, holds while high
// - reset term clears, preset term sets, no clock
// - buried logic cell feeds only internal feedback
// - buried cell can sample a pin as input
// - driver always on, always off, or by term
// - term control picks one of two shared enables
// - pin is output, input, bidirectional or bus
`timescale 1ns/100ps
`default_nettype none
module logic_block
   import logic_block_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [9:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic [25:0] SWITCH_IN,
   input wire logic [3:0] CLK_PIN,
   input wire logic [5:0] IO_IN,
   output logic [5:0] IO_OUT,
   output logic [5:0] IO_OE_N,
   output logic [11:0] MC_FEEDBACK,
   output logic [5:0] PIN_FEEDBACK
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] be_merge(
      input logic [31:0] old_word,
      input logic [31:0] new_word,
      input logic [3:0] be
   );
      logic [31:0] res;
      res = old_word;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_word[b*8 +: 8];
         end
      end
      return res;
   endfunction : be_merge

   function automatic logic at_word(
      input logic [9:0] addr,
      input logic [9:0] base,
      input logic [9:0] idx,
      input logic [9:0] stride
   );
      return addr == 10'(base + idx * stride);
   endfunction : at_word

   // clusters n-1 .. n+2 clipped to the block
   function automatic logic [11:0] reach_mask(input int n);
      logic [11:0] m;
      m = 12'h000;
      for (int c = 0; c < NUM_MC; c++) begin
         if (c >= n - 1 && c <= n + 2) begin
            m[c] = 1'b1;
         end
      end
      return m;
   endfunction : reach_mask

   // ****************************************
   // declarations
   // ****************************************
   term_fuse_t fuse [NUM_TERMS];
   term_fuse_t next_fuse [NUM_TERMS];
   mc_cfg_t mc_cfg [NUM_MC];
   mc_cfg_t next_mc_cfg [NUM_MC];
   logic [1:0] steer [NUM_MC];
   logic [1:0] next_steer [NUM_MC];
   oe_mode_t io_mode [NUM_IO];
   oe_mode_t next_io_mode [NUM_IO];
   logic ack, next_ack;
   logic [31:0] rdata, next_rdata;
   logic [3:0] clk_prev, next_clk_prev;
   logic [3:0] clk_rise;
   logic req, rd_first, wr_go;
   logic [NUM_TERMS-1:0] term;
   logic [11:0] cluster_sum;
   logic [11:0] take [NUM_MC];
   logic [11:0] mc_sum;
   logic [11:0] mc_q;
   init_terms_t init;

   // ****************************************
   // avalon slave, one wait state
   // ****************************************
   always_comb begin
      req = AVS_READ || AVS_WRITE;
      AVS_WAITREQUEST = req && !ack;
      rd_first = AVS_READ && !ack;
      wr_go = AVS_WRITE && ack;
      next_ack = req && !ack;
      AVS_READDATA = rdata;
   end

   always_comb begin
      next_rdata = rdata;
      if (rd_first) begin
         next_rdata = 32'h00000000;
         for (int t = 0; t < NUM_TERMS; t++) begin
            if (at_word(AVS_ADDRESS, TERM_BASE, 10'(t), TERM_STRIDE)) begin
               next_rdata[25:0] = fuse[t].true_mask;
            end
            if (at_word(AVS_ADDRESS, TERM_BASE + TERM_COMP_OFS, 10'(t), TERM_STRIDE)) begin
               next_rdata[25:0] = fuse[t].comp_mask;
            end
         end
         for (int n = 0; n < NUM_MC; n++) begin
            if (at_word(AVS_ADDRESS, MC_BASE, 10'(n), WORD_STRIDE)) begin
               next_rdata[5:0] = mc_cfg[n];
            end
            if (at_word(AVS_ADDRESS, STEER_BASE, 10'(n), WORD_STRIDE)) begin
               next_rdata[1:0] = steer[n];
            end
         end
         for (int i = 0; i < NUM_IO; i++) begin
            if (at_word(AVS_ADDRESS, IO_BASE, 10'(i), WORD_STRIDE)) begin
               next_rdata[1:0] = io_mode[i];
            end
         end
         if (AVS_ADDRESS == STATUS_ADDR) begin
            next_rdata[STATUS_MC_LSB +: NUM_MC] = MC_FEEDBACK;
            next_rdata[STATUS_PIN_LSB +: NUM_IO] = PIN_FEEDBACK;
         end
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ack <= 1'b0;
         rdata <= 32'h00000000;
      end else begin
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   // ****************************************
   // configuration store
   // ****************************************
   always_comb begin
      logic [31:0] w;
      w = 32'h00000000;
      next_fuse = fuse;
      next_mc_cfg = mc_cfg;
      next_steer = steer;
      next_io_mode = io_mode;
      if (wr_go) begin
         for (int t = 0; t < NUM_TERMS; t++) begin
            if (at_word(AVS_ADDRESS, TERM_BASE, 10'(t), TERM_STRIDE)) begin
               w = be_merge({6'h00, fuse[t].true_mask}, AVS_WRITEDATA, AVS_BYTEENABLE);
               next_fuse[t].true_mask = w[25:0];
            end
            if (at_word(AVS_ADDRESS, TERM_BASE + TERM_COMP_OFS, 10'(t), TERM_STRIDE)) begin
               w = be_merge({6'h00, fuse[t].comp_mask}, AVS_WRITEDATA, AVS_BYTEENABLE);
               next_fuse[t].comp_mask = w[25:0];
            end
         end
         for (int n = 0; n < NUM_MC; n++) begin
            if (at_word(AVS_ADDRESS, MC_BASE, 10'(n), WORD_STRIDE) && AVS_BYTEENABLE[0]) begin
               next_mc_cfg[n] = AVS_WRITEDATA[5:0];
            end
            if (at_word(AVS_ADDRESS, STEER_BASE, 10'(n), WORD_STRIDE)
                && AVS_BYTEENABLE[0]) begin
               next_steer[n] = AVS_WRITEDATA[1:0];
            end
         end
         for (int i = 0; i < NUM_IO; i++) begin
            if (at_word(AVS_ADDRESS, IO_BASE, 10'(i), WORD_STRIDE) && AVS_BYTEENABLE[0]) begin
               next_io_mode[i] = oe_mode_t'(AVS_WRITEDATA[1:0]);
            end
         end
      end
   end

   // all-ones masks hold every unwritten term false
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         for (int t = 0; t < NUM_TERMS; t++) begin
            fuse[t] <= {MASK_RESET, MASK_RESET};
         end
         for (int n = 0; n < NUM_MC; n++) begin
            mc_cfg[n] <= MC_CFG_RESET;
            steer[n] <= STEER_RESET;
         end
         for (int i = 0; i < NUM_IO; i++) begin
            io_mode[i] <= IO_MODE_RESET;
         end
      end else begin
         fuse <= next_fuse;
         mc_cfg <= next_mc_cfg;
         steer <= next_steer;
         io_mode <= next_io_mode;
      end
   end

   // ****************************************
   // clock pin edges
   // ****************************************
   always_comb begin
      next_clk_prev = CLK_PIN;
      clk_rise = CLK_PIN & ~clk_prev;
   end

   // preset high so a pin already high at release is no edge
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         clk_prev <= CLK_PIN_RESET;
      end else begin
         clk_prev <= next_clk_prev;
      end
   end

   // ****************************************
   // product-term array
   // ****************************************
   // a term set for both senses of one input can never be true
   always_comb begin
      for (int t = 0; t < NUM_TERMS; t++) begin
         term[t] = &(SWITCH_IN | ~fuse[t].true_mask)
            & &(~SWITCH_IN | ~fuse[t].comp_mask);
      end
      init.reset = term[TERM_RESET];
      init.preset = term[TERM_PRESET];
   end

   // ****************************************
   // term allocator
   // ****************************************
   // cluster c goes to macrocell c-2+steer; codes pointing outside drop it
   always_comb begin
      for (int c = 0; c < NUM_MC; c++) begin
         cluster_sum[c] = |term[c*CLUSTER_TERMS +: CLUSTER_TERMS];
      end
      for (int n = 0; n < NUM_MC; n++) begin
         take[n] = 12'h000;
         for (int k = 0; k < 4; k++) begin
            if (n + 2 - k >= 0 && n + 2 - k < NUM_MC) begin
               take[n][n+2-k] = (steer[n+2-k] == 2'(k));
            end
         end
         mc_sum[n] = |(take[n] & cluster_sum);
      end
   end

   // ****************************************
   // macrocells and pins
   // ****************************************
   // even slots are output cells, odd slots buried
   for (genvar n = 0; n < NUM_MC; n++) begin : g_mc
      macrocell #(
         .BURIED(n % 2 == 1)
      ) u_mc (
         .clk(CLK),
         .rst(SYS_RST),
         .cfg(mc_cfg[n]),
         .sum(mc_sum[n]),
         .pin_in(IO_IN[n/2]),
         .clk_pins(CLK_PIN),
         .clk_rise(clk_rise),
         .init(init),
         .q_out(mc_q[n])
      );
   end

   // buried results only return as feedback
   for (genvar i = 0; i < NUM_IO; i++) begin : g_io
      io_cell u_io (
         .mode(io_mode[i]),
         .oe_terms({term[TERM_OE1], term[TERM_OE0]}),
         .data(mc_q[2*i]),
         .pin_out(IO_OUT[i]),
         .pin_oe_n(IO_OE_N[i])
      );
   end

   always_comb begin
      MC_FEEDBACK = mc_q;
      PIN_FEEDBACK = IO_IN;
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   chk_bus_wait: assert property (req && !ack |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
      else $error("bus request not answered after one wait state");
   chk_io_write: assert property (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == IO_BASE
      && AVS_BYTEENABLE[0] |=> io_mode[0] == oe_mode_t'($past(AVS_WRITEDATA[1:0])))
      else $error("enable mode write did not land");
   for (genvar n = 0; n < NUM_MC; n++) begin : g_chk_mc
      chk_cluster_reach: assert property (mc_sum[n] |-> |(cluster_sum & reach_mask(n)))
         else $error("macrocell summed a cluster out of its reach");
      chk_term_budget: assert property ($countones(take[n]) <= MAX_CELL_TERMS / 4)
         else $error("macrocell took more than sixteen terms");
   end
   for (genvar i = 0; i < NUM_IO; i++) begin : g_chk_io
      chk_oe_never: assert property (io_mode[i] == OE_NEVER |-> IO_OE_N[i])
         else $error("disabled driver is enabled");
      chk_oe_term: assert property (
         io_mode[i] == OE_TERM1 |-> IO_OE_N[i] == !term[TERM_OE1])
         else $error("driver does not follow its enable term");
   end

endmodule : logic_block
`default_nettype wire

// >>> board_model.sv
// board-side circuitry on the six bidirectional pins, with pull-ups
`timescale 1ns/100ps
`default_nettype none
module board_model
   import logic_block_pkg::*;
(
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe_n,
   input wire logic [5:0] drive_en,
   input wire logic [5:0] drive_val,
   output logic [5:0] pin_level
);
   // ****************************************
   // wire resolution
   // ****************************************
   always_comb begin
      for (int i = 0; i < NUM_IO; i++) begin
         if (!pin_oe_n[i] && drive_en[i]) begin
            pin_level[i] = 1'bx; // contention is never hidden
         end else if (!pin_oe_n[i]) begin
            pin_level[i] = pin_out[i];
         end else if (drive_en[i]) begin
            pin_level[i] = drive_val[i];
         end else begin
            // a released pin goes to the pull-up, not to its last value
            pin_level[i] = 1'b1;
         end
      end
   end
endmodule : board_model
`default_nettype wire

// >>> tb_top.sv
// self-checking testbench of the product-term logic block
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import logic_block_pkg::*;
;
   logic clk, sys_rst, avs_read, avs_write, avs_waitrequest;
   logic [9:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable, clk_pin;
   logic [25:0] switch_in;
   logic [5:0] io_in, io_out, io_oe_n, pin_feedback, drive_en, drive_val;
   logic [11:0] mc_feedback;
   logic [5:0] expo;
   int n_mismatch, n_compared;

   logic_block i_dut (.CLK(clk), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address),
      .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
      .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(avs_waitrequest), .SWITCH_IN(switch_in), .CLK_PIN(clk_pin),
      .IO_IN(io_in), .IO_OUT(io_out), .IO_OE_N(io_oe_n), .MC_FEEDBACK(mc_feedback),
      .PIN_FEEDBACK(pin_feedback));
   board_model i_board (.pin_out(io_out), .pin_oe_n(io_oe_n), .drive_en(drive_en),
      .drive_val(drive_val), .pin_level(io_in));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ****************************************
   // access tasks
   // ****************************************
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // request held until the rising edge that sees waitrequest low; q taken there,
   // then half a cycle passes so the write has landed before anything is checked
   task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(negedge clk);
   endtask : bus

   task term(input int t, input logic [25:0] tm, input logic [25:0] cm);
      bus(1'b1, TERM_BASE + 10'(t) * TERM_STRIDE, {6'h00, tm});
      bus(1'b1, TERM_BASE + 10'(t) * TERM_STRIDE + TERM_COMP_OFS, {6'h00, cm});
   endtask : term

   task cfg(input int n, input logic [5:0] v);
      bus(1'b1, MC_BASE + 10'(n) * WORD_STRIDE, {26'h0, v});
   endtask : cfg

   task word(input logic [9:0] base, input int n, input logic [1:0] v);
      bus(1'b1, base + 10'(n) * WORD_STRIDE, {30'h0, v});
   endtask : word

   // inputs change on the edge, outputs are looked at mid-cycle
   task sw(input logic [25:0] v);
      @(posedge clk);
      switch_in <= v;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : sw

   task pin(input int p, input logic v);
      @(posedge clk);
      clk_pin[p] <= v;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : pin

   task mc(input logic [11:0] exp);
      chk("mc_feedback", 32'(mc_feedback), 32'(exp));
   endtask : mc

   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   // ****************************************
   // watchdog, far beyond the few hundred cycles the tests need
   // ****************************************
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end

   // ****************************************
   // tests
   // ****************************************
   initial begin
      sys_rst = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      {switch_in, clk_pin, drive_en, drive_val} = '0;
      n_mismatch = 0;
      n_compared = 0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      bus(1'b0, STATUS_ADDR, 32'h0);
      chk("status", q, 32'h0003f000);
      chk("io_oe_n", 32'(io_oe_n), 32'h3f);
      bus(1'b0, STEER_BASE, 32'h0);
      chk("steer", q, 32'h2);
      bus(1'b1, 10'h3f0, 32'hffffffff);
      bus(1'b0, 10'h3f0, 32'h0);
      chk("unmapped", q, 32'h0);
      bus(1'b1, MC_BASE + 10'h02c, 32'hffffffc0);
      bus(1'b0, MC_BASE + 10'h02c, 32'h0);
      chk("cfg_high_bits", q, 32'h0);
      // literal of a true and a complemented input, then polarity
      term(0, 26'h1, 26'h2000000);
      sw(26'h1);
      mc(12'h001);
      sw(26'h2000001);
      mc(12'h000);
      cfg(0, 6'h08);
      sw(26'h0);
      mc(12'h001);
      cfg(0, 6'h00);
      // every steer code, cluster 11 also past the top slot
      term(8, 26'h2, 26'h0);
      term(44, 26'h2, 26'h0);
      for (int code = 0; code < 4; code++) begin
         word(STEER_BASE, 2, 2'(code));
         word(STEER_BASE, 11, 2'(code));
         sw(26'h2);
         mc((12'h1 << code) | ((code < 3) ? (12'h1 << (9 + code)) : 12'h0));
      end
      word(STEER_BASE, 2, 2'h2);
      term(8, MASK_RESET, MASK_RESET);
      term(44, MASK_RESET, MASK_RESET);
      // d register on clock pin 1
      term(0, 26'h1, 26'h0);
      cfg(0, 6'h11);
      word(IO_BASE, 0, 2'h0);
      sw(26'h1);
      mc(12'h000);
      pin(1, 1'b1);
      mc(12'h001);
      chk("io_pin", {30'h0, io_oe_n[0], io_out[0]}, 32'h1);
      sw(26'h0);
      pin(0, 1'b1);
      pin(0, 1'b0);
      mc(12'h001);
      pin(1, 1'b0);
      pin(1, 1'b1);
      mc(12'h000);
      // toggle register
      cfg(0, 6'h15);
      sw(26'h1);
      for (int k = 0; k < 2; k++) begin
         pin(1, 1'b0);
         pin(1, 1'b1);
         mc(12'(k == 0));
      end
      // latch gated by pin 2
      cfg(0, 6'h23);
      mc(12'h001);
      pin(2, 1'b1);
      sw(26'h0);
      mc(12'h001);
      pin(2, 1'b0);
      mc(12'h000);
      // shared preset and reset terms on two registers
      cfg(0, 6'h11);
      cfg(2, 6'h11);
      term(50, 26'h4, 26'h0);
      term(51, 26'h8, 26'h0);
      sw(26'h8);
      mc(12'h005);
      sw(26'hc);
      mc(12'h000);
      sw(26'h8);
      sw(26'h4);
      mc(12'h000);
      sw(26'h0);
      mc(12'h000);
      // every driver mode, with both shared enable terms
      cfg(0, 6'h00);
      term(48, 26'h10, 26'h0);
      term(49, 26'h20, 26'h0);
      for (int m = 0; m < 4; m++) begin
         word(IO_BASE, 0, 2'(m));
         for (int s = 0; s < 2; s++) begin
            sw(s ? 26'h21 : 26'h10);
            expo = {5'h1f, (m == 1) || (m == 2 && s == 1) || (m == 3 && s == 0)};
            chk("io_oe_n", 32'(io_oe_n), 32'(expo));
            chk("pin_feedback", 32'(pin_feedback[0]), 32'(expo[0] || s == 1));
         end
      end
      // buried slot 1 samples pin 0, driven by the board while disabled
      word(IO_BASE, 0, 2'h1);
      cfg(1, 6'h12);
      @(posedge clk);
      drive_en <= 6'h01;
      drive_val <= 6'h00;
      sw(26'h0);
      pin(1, 1'b0);
      pin(1, 1'b1);
      mc(12'h000);
      @(posedge clk);
      drive_val <= 6'h01;
      sw(26'h0);
      chk("pin_feedback", 32'(pin_feedback), 32'h3f);
      mc(12'h000);
      pin(1, 1'b0);
      pin(1, 1'b1);
      mc(12'h002);
      chk("io_out", 32'(io_out), 32'h0);
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
